// ==== inc/seq_params.svh ====
// Purpose: constants of the program sequencer
// Assumes: included by its bare name
// Notes: definitions only
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

`define PC_W 11
`define ROM_DW 16
`define ROM_WORDS 2048
`define NIB_W 4
`define RAM_AW 7
`define INT_N 7
`define STACK_DEPTH 8
`define STACK_PW 3

`define RESET_VEC 11'h000
`define VEC_DIV 11'h004
`define VEC_TM0 11'h008
`define VEC_PCH 11'h00C
`define VEC_EXT 11'h014
`define VEC_SRX 11'h018
`define VEC_STX 11'h01C
`define VEC_TM1 11'h020

`define INT_DIV 3'h0
`define INT_TM0 3'h1
`define INT_PCH 3'h2
`define INT_EXT 3'h3
`define INT_SRX 3'h4
`define INT_STX 3'h5
`define INT_TM1 3'h6

`define TBL_BASE 11'h600
`define PC_ONE 11'h001
`define PTR_ONE 3'h1

`endif

// ==== inc/seq_pkg.sv ====
// Purpose: types of the program sequencer
// Assumes: seq_params.svh holds the figures
// Notes: state structs, one per module
`default_nettype none
`include "seq_params.svh"

package seq_pkg;

	typedef enum logic [2:0]
	{
		op_step = 3'h0,
		op_jump = 3'h1,
		op_call = 3'h2,
		return_op = 3'h3,
		table_read_op = 3'h4,
		op_load_ptr_low = 3'h5,
		op_load_ptr_high = 3'h6,
		op_load_work = 3'h7
	} op_t;

	typedef enum logic
	{
		ts_idle = 1'b0,
		ts_wait = 1'b1
	} tbl_state_t;

	typedef struct packed
	{
		logic [`PC_W-1:0] pc;
		logic [`NIB_W-1:0] table_ptr_low;
		logic [`NIB_W-1:0] table_ptr_high;
		logic [`NIB_W-1:0] work_nibble_reg;
		logic [`INT_N-1:0] int_flags;
		logic int_open;
		logic ext_s1;
		logic ext_s2;
		logic ext_prev;
		logic [3:0] pch_s1;
		logic [3:0] pch_s2;
		logic [3:0] pch_prev;
		logic clr_s1;
		logic clr_s2;
		tbl_state_t tstate;
		logic [1:0] tsel;
		logic [`RAM_AW-1:0] taddr;
		logic ram_we;
		logic [`RAM_AW-1:0] ram_addr;
		logic [`NIB_W-1:0] ram_data;
		logic int_taken;
		logic [2:0] int_src;
	} seq_state_t;

	typedef struct packed
	{
		logic [`STACK_PW-1:0] ptr;
		logic [`STACK_DEPTH-1:0][`PC_W-1:0] mem;
	} stack_state_t;

	typedef struct packed
	{
		logic [`ROM_WORDS-1:0][`ROM_DW-1:0] mem;
		logic [`ROM_DW-1:0] fetch_data;
		logic [`ROM_DW-1:0] tbl_data;
	} rom_state_t;

endpackage : seq_pkg

`default_nettype wire

// ==== inc/seq_if.sv ====
// Purpose: links the sequencer to its stack and program memory
// Assumes: one clock
// Notes: modports per party
`default_nettype none
`timescale 1ns/1ps
`include "seq_params.svh"

interface seq_if;
	logic push;
	logic pop;
	logic [`PC_W-1:0] push_data;
	logic [`PC_W-1:0] top;
	logic [`STACK_PW-1:0] ptr;
	logic [`PC_W-1:0] fetch_addr;
	logic [`PC_W-1:0] tbl_addr;
	logic wr_en;
	logic [`PC_W-1:0] wr_addr;
	logic [`ROM_DW-1:0] wr_data;
	logic [`ROM_DW-1:0] fetch_data;
	logic [`ROM_DW-1:0] tbl_data;

	modport stk (input push, pop, push_data, output top, ptr);
	modport stk_user (output push, pop, push_data, input top, ptr);
	modport rom (input fetch_addr, tbl_addr, wr_en, wr_addr, wr_data,
		output fetch_data, tbl_data);
	modport rom_user (output fetch_addr, tbl_addr, wr_en, wr_addr, wr_data,
		input fetch_data, tbl_data);
endinterface : seq_if

`default_nettype wire

// ==== core/return_stack.sv ====
// Purpose: eight-level return address stack
// Assumes: push and pop never in the same cycle
// Notes: circular, a ninth push overwrites the oldest
`default_nettype none
`timescale 1ns/1ps
`include "seq_params.svh"

module return_stack
	import seq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	seq_if.stk sif
);

	stack_state_t s_q;
	stack_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		if (sif.push)
		begin
			s_d.mem[s_q.ptr] = sif.push_data;
			s_d.ptr = s_q.ptr + `PTR_ONE;
		end
		else if (sif.pop)
		begin
			s_d.ptr = s_q.ptr - `PTR_ONE;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign sif.top = s_q.mem[s_q.ptr - `PTR_ONE];
	assign sif.ptr = s_q.ptr;

	stack_wrap_a: assert property (@(posedge clock) disable iff (!nrst)
		sif.push |=> (s_q.ptr == $past(s_q.ptr) + 3'h1)
			&& (sif.top == $past(sif.push_data)))
		else $error("stack push did not land on top");

	stack_pop_a: assert property (@(posedge clock) disable iff (!nrst)
		sif.push ##1 sif.pop |=> s_q.ptr == $past(s_q.ptr, 2))
		else $error("stack pop did not undo push");

endmodule : return_stack

`default_nettype wire

// ==== core/program_rom.sv ====
// Purpose: 2048 x 16 program memory with fetch and table ports
// Assumes: written only while loading code
// Notes: both read ports registered
`default_nettype none
`timescale 1ns/1ps
`include "seq_params.svh"

module program_rom
	import seq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	seq_if.rom rif
);

	rom_state_t s_q;
	rom_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.fetch_data = s_q.mem[rif.fetch_addr];
		s_d.tbl_data = s_q.mem[rif.tbl_addr];
		if (rif.wr_en)
			s_d.mem[rif.wr_addr] = rif.wr_data;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			s_q.fetch_data <= '0;
			s_q.tbl_data <= '0;
			s_q.mem <= s_d.mem;
		end
		else
			s_q <= s_d;
	end

	assign rif.fetch_data = s_q.fetch_data;
	assign rif.tbl_data = s_q.tbl_data;

endmodule : program_rom

`default_nettype wire

// ==== core/program_sequencer_stack.sv ====
// Purpose: program counter, vectors, return stack and table read
// Assumes: ops come from the core decoder on the same clock
// Notes: Contract
// Contract
// - an 11-bit counter addresses the 2048-word program memory
// - reset loads the counter with 000H
// - vectors 004H divider, 008H timer zero, 00CH pin change, in that priority
// - external pin vectors to 014H, serial receive to 018H
// - serial transmit vectors to 01CH, timer one to 020H, lowest
// - jump and call load the encoded target
// - call pushes the counter plus one, interrupt the counter, onto an 8 x 11 stack
// - return pops the top entry into the counter
// - ninth push drops the oldest entry
// - 000H-5FFH code only, 600H-7FFH code and table
// - table holds 2048 nibble elements
// - two table pointers, each loaded by its own move op
// - table read writes the selected nibble into data memory
// - external interrupt and reset pins are active low, no pull-up
// - each pin change input interrupts only while configured as input
// - a 4-bit work nibble register takes part in table addressing
`default_nettype none
`timescale 1ns/1ps
`include "seq_params.svh"

module program_sequencer_stack
	import seq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic chip_clear_pin_n,
	input wire logic ext_int_pin_n,
	input wire logic [3:0] pin_change_port,
	input wire logic [3:0] pin_change_is_input,
	input wire logic div_event,
	input wire logic tm0_event,
	input wire logic srx_event,
	input wire logic stx_event,
	input wire logic tm1_event,
	input wire logic [`INT_N-1:0] int_mask,
	input wire logic op_valid,
	input wire op_t op_kind,
	input wire logic [`PC_W-1:0] op_target,
	input wire logic [`NIB_W-1:0] op_data,
	input wire logic [`RAM_AW-1:0] op_ram_addr,
	input wire logic prog_we,
	input wire logic [`PC_W-1:0] prog_addr,
	input wire logic [`ROM_DW-1:0] prog_data,
	output logic op_ready,
	output logic [`PC_W-1:0] pc,
	output logic [`ROM_DW-1:0] instr,
	output logic ram_we,
	output logic [`RAM_AW-1:0] ram_addr,
	output logic [`NIB_W-1:0] ram_data,
	output logic int_taken,
	output logic [2:0] int_src
);

	seq_state_t s_q;
	seq_state_t s_d;
	seq_if sif ();

	logic clear_now;
	logic take;
	logic accept;
	logic [`INT_N-1:0] req;
	logic [2:0] pick;
	logic [`PC_W-1:0] elem;
	logic [3:0] pch_fall;
	logic ext_fall;

	function automatic logic [2:0] first_req(input logic [`INT_N-1:0] r);
		logic [2:0] idx;
		idx = `INT_TM1;
		for (int i = `INT_N - 1; i >= 0; i--)
			if (r[i])
				idx = 3'(i);
		return idx;
	endfunction : first_req

	function automatic logic [`PC_W-1:0] vec_of(input logic [2:0] idx);
		logic [`PC_W-1:0] v;
		unique case (idx)
			`INT_DIV: v = `VEC_DIV;
			`INT_TM0: v = `VEC_TM0;
			`INT_PCH: v = `VEC_PCH;
			`INT_EXT: v = `VEC_EXT;
			`INT_SRX: v = `VEC_SRX;
			`INT_STX: v = `VEC_STX;
			`INT_TM1: v = `VEC_TM1;
			default: v = `RESET_VEC;
		endcase
		return v;
	endfunction : vec_of

	// table element and its word, upper quarter only
	function automatic logic [`PC_W-1:0] tbl_word(input logic [`PC_W-1:0] e);
		return `TBL_BASE + {2'b00, e[`PC_W-1:2]};
	endfunction : tbl_word

	// pin edges, read from second sync stage only
	assign ext_fall = s_q.ext_prev & ~s_q.ext_s2;
	assign pch_fall = s_q.pch_prev & ~s_q.pch_s2 & pin_change_is_input;
	assign clear_now = ~s_q.clr_s2;
	assign req = s_q.int_flags & int_mask;
	assign pick = first_req(req);
	assign take = s_q.int_open & (|req) & ~clear_now;
	assign accept = op_valid & ~take & ~clear_now;
	assign elem = 11'({s_q.table_ptr_high, s_q.table_ptr_low, s_q.work_nibble_reg});

	always_comb
	begin
		s_d = s_q;
		s_d.ext_s1 = ext_int_pin_n;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_prev = s_q.ext_s2;
		s_d.pch_s1 = pin_change_port;
		s_d.pch_s2 = s_q.pch_s1;
		s_d.pch_prev = s_q.pch_s2;
		s_d.clr_s1 = chip_clear_pin_n;
		s_d.clr_s2 = s_q.clr_s1;
		s_d.int_taken = 1'b0;
		s_d.ram_we = 1'b0;
		sif.push = 1'b0;
		sif.pop = 1'b0;
		sif.push_data = s_q.pc;
		// clear of the taken source first, so new events win
		if (take)
			s_d.int_flags[pick] = 1'b0;
		if (div_event)
			s_d.int_flags[`INT_DIV] = 1'b1;
		if (tm0_event)
			s_d.int_flags[`INT_TM0] = 1'b1;
		if (|pch_fall)
			s_d.int_flags[`INT_PCH] = 1'b1;
		if (ext_fall)
			s_d.int_flags[`INT_EXT] = 1'b1;
		if (srx_event)
			s_d.int_flags[`INT_SRX] = 1'b1;
		if (stx_event)
			s_d.int_flags[`INT_STX] = 1'b1;
		if (tm1_event)
			s_d.int_flags[`INT_TM1] = 1'b1;
		// table read second cycle: nibble out of the fetched word
		unique case (s_q.tstate)
			ts_idle:
			begin
			end
			ts_wait:
			begin
				s_d.ram_we = 1'b1;
				s_d.ram_addr = s_q.taddr;
				s_d.ram_data = sif.tbl_data[{s_q.tsel, 2'b00} +: `NIB_W];
			end
		endcase
		s_d.tstate = ts_idle;
		if (take)
		begin
			sif.push = 1'b1;
			sif.push_data = s_q.pc;
			s_d.pc = vec_of(pick);
			s_d.int_open = 1'b0;
			s_d.int_taken = 1'b1;
			s_d.int_src = pick;
		end
		else if (accept)
		begin
			s_d.pc = s_q.pc + `PC_ONE;
			unique case (op_kind)
				op_step:
				begin
				end
				op_jump:
					s_d.pc = op_target;
				op_call:
				begin
					sif.push = 1'b1;
					sif.push_data = s_q.pc + `PC_ONE;
					s_d.pc = op_target;
				end
				return_op:
				begin
					sif.pop = 1'b1;
					s_d.pc = sif.top;
					s_d.int_open = 1'b1;
				end
				table_read_op:
				begin
					s_d.tstate = ts_wait;
					s_d.taddr = op_ram_addr;
					s_d.tsel = elem[1:0];
				end
				op_load_ptr_low:
					s_d.table_ptr_low = op_data;
				op_load_ptr_high:
					s_d.table_ptr_high = op_data;
				op_load_work:
					s_d.work_nibble_reg = op_data;
			endcase
		end
		if (clear_now)
		begin
			s_d.pc = `RESET_VEC;
			s_d.int_flags = '0;
			s_d.int_open = 1'b1;
			s_d.tstate = ts_idle;
			s_d.ram_we = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			s_q <= '0;
			s_q.pc <= `RESET_VEC;
			s_q.int_open <= 1'b1;
			s_q.ext_s1 <= 1'b1;
			s_q.ext_s2 <= 1'b1;
			s_q.ext_prev <= 1'b1;
			s_q.pch_s1 <= 4'hF;
			s_q.pch_s2 <= 4'hF;
			s_q.pch_prev <= 4'hF;
			s_q.clr_s1 <= 1'b1;
			s_q.clr_s2 <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign sif.fetch_addr = s_q.pc;
	assign sif.tbl_addr = tbl_word(elem);
	assign sif.wr_en = prog_we;
	assign sif.wr_addr = prog_addr;
	assign sif.wr_data = prog_data;

	return_stack u_stack
	(
		.clock(clock),
		.nrst(nrst),
		.sif(sif.stk)
	);

	program_rom u_rom
	(
		.clock(clock),
		.nrst(nrst),
		.rif(sif.rom)
	);

	assign op_ready = ~take & ~clear_now;
	assign pc = s_q.pc;
	assign instr = sif.fetch_data;
	assign ram_we = s_q.ram_we;
	assign ram_addr = s_q.ram_addr;
	assign ram_data = s_q.ram_data;
	assign int_taken = s_q.int_taken;
	assign int_src = s_q.int_src;

	reset_pc_a: assert property (@(posedge clock)
		!nrst |=> pc == 11'h000)
		else $error("counter not at zero after reset");

	step_pc_a: assert property (@(posedge clock) disable iff (!nrst)
		accept && op_kind == op_step |=> pc == $past(pc) + 11'h001)
		else $error("counter did not step");

	jump_load_a: assert property (@(posedge clock) disable iff (!nrst)
		accept && (op_kind == op_jump || op_kind == op_call) |=> pc == $past(op_target))
		else $error("jump target not loaded");

	div_vector_a: assert property (@(posedge clock) disable iff (!nrst)
		take && req[0] |=> pc == 11'h004 && int_src == 3'h0)
		else $error("divider vector wrong");

	ext_vector_a: assert property (@(posedge clock) disable iff (!nrst)
		take && req[3:0] == 4'h8 |=> pc == 11'h014)
		else $error("external vector wrong");

	tm1_vector_a: assert property (@(posedge clock) disable iff (!nrst)
		take && req == 7'h40 |=> pc == 11'h020)
		else $error("timer one vector wrong");

	call_return_a: assert property (@(posedge clock) disable iff (!nrst)
		accept && op_kind == op_call ##1 accept && op_kind == return_op
			|=> pc == $past(pc, 2) + 11'h001)
		else $error("return address lost");

	table_write_a: assert property (@(posedge clock) disable iff (!nrst)
		accept && op_kind == table_read_op && !clear_now ##1 !clear_now
			|=> ram_we && ram_addr == $past(op_ram_addr, 2))
		else $error("table nibble not written");

	pin_dir_a: assert property (@(posedge clock) disable iff (!nrst)
		!s_q.int_flags[2] ##1 s_q.int_flags[2] |-> $past(|(pch_fall & pin_change_is_input)))
		else $error("pin change raised from an output pin");

	ext_low_a: assert property (@(posedge clock) disable iff (!nrst)
		!s_q.int_flags[3] ##1 s_q.int_flags[3] |-> $past(s_q.ext_prev && !s_q.ext_s2))
		else $error("external flag without falling edge");

endmodule : program_sequencer_stack

`default_nettype wire

// ==== sim/program_sequencer_stack_tb_top.sv ====
// Purpose: self-checking bench of the program sequencer
// Assumes: ops refused while op_ready low; pc holds when no op
// Notes: table rows first, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"

module program_sequencer_stack_tb_top
	import seq_pkg::*;
;
	typedef struct packed
	{
		op_t k;
		logic [10:0] t;
		logic [10:0] e;
	} row_t;

	logic clock, nrst, clr_n, ext_n, op_valid, prog_we, op_ready, ram_we, int_taken;
	logic [3:0] pins, pin_in, op_data, ram_data;
	logic [4:0] evs;
	logic [6:0] mask, op_ram_addr, ram_addr;
	logic [10:0] op_target, prog_addr, pc;
	logic [15:0] prog_data, instr;
	logic [2:0] int_src;
	op_t op_kind;
	logic [10:0] pre [0:8];
	int error_cnt, tests_run, i, j;
	row_t rows [6] = '{'{op_jump, 11'h7FF, 11'h7FF}, '{op_step, 11'h000, 11'h000},
		'{op_jump, 11'h5FF, 11'h5FF}, '{op_step, 11'h000, 11'h600},
		'{op_jump, 11'h123, 11'h123}, '{op_step, 11'h000, 11'h124}};
	logic [10:0] vecs [5] = '{11'h004, 11'h008, 11'h018, 11'h01C, 11'h020};
	logic [2:0] srcs [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};

	program_sequencer_stack i_dut (.clock(clock), .nrst(nrst), .chip_clear_pin_n(clr_n),
		.ext_int_pin_n(ext_n), .pin_change_port(pins), .pin_change_is_input(pin_in),
		.div_event(evs[0]), .tm0_event(evs[1]), .srx_event(evs[2]), .stx_event(evs[3]),
		.tm1_event(evs[4]), .int_mask(mask), .op_valid(op_valid), .op_kind(op_kind),
		.op_target(op_target), .op_data(op_data), .op_ram_addr(op_ram_addr),
		.prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
		.op_ready(op_ready), .pc(pc), .instr(instr), .ram_we(ram_we),
		.ram_addr(ram_addr), .ram_data(ram_data), .int_taken(int_taken), .int_src(int_src));

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task end_sim;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	task do_op(input op_t k, input logic [10:0] t, input logic [3:0] dt, input logic [6:0] ra);
		int n;
		@(posedge clock);
		op_valid <= 1'b1;
		op_kind <= k;
		op_target <= t;
		op_data <= dt;
		op_ram_addr <= ra;
		for (n = 0; n < 20; n++)
		begin
			@(negedge clock);
			if (op_ready === 1'b1)
				break;
		end
		chk("op_ready", 16'h1, {15'h0, op_ready});
		@(posedge clock);
		op_valid <= 1'b0;
		@(negedge clock);
	endtask : do_op

	task wr(input logic [10:0] a, input logic [15:0] dt);
		@(posedge clock);
		prog_we <= 1'b1;
		prog_addr <= a;
		prog_data <= dt;
		@(posedge clock);
		prog_we <= 1'b0;
		@(negedge clock);
	endtask : wr

	task pulse(input logic [4:0] m);
		@(posedge clock);
		evs <= m;
		@(posedge clock);
		evs <= 5'h00;
	endtask : pulse

	task wait_int(input logic [10:0] vec, input logic [2:0] src);
		int n;
		for (n = 0; n < 12; n++)
		begin
			@(negedge clock);
			if (int_taken === 1'b1)
				break;
		end
		chk("int_taken", 16'h1, {15'h0, int_taken});
		chk("pc", {5'h00, vec}, {5'h00, pc});
		chk("int_src", {13'h0, src}, {13'h0, int_src});
	endtask : wait_int

	task no_int;
		int n;
		for (n = 0; n < 6; n++)
		begin
			@(negedge clock);
			chk("int_taken", 16'h0, {15'h0, int_taken});
		end
	endtask : no_int

	task tbl(input logic [3:0] hi, lo, wn, input logic [6:0] ra, input logic [3:0] e);
		int n;
		do_op(op_t'(3'h6), 11'h000, hi, 7'h00);
		do_op(op_t'(3'h5), 11'h000, lo, 7'h00);
		do_op(op_t'(3'h7), 11'h000, wn, 7'h00);
		do_op(table_read_op, 11'h000, 4'h0, ra);
		for (n = 0; n < 4; n++)
		begin
			if (ram_we === 1'b1)
				break;
			@(negedge clock);
		end
		chk("ram_we", 16'h1, {15'h0, ram_we});
		chk("ram_addr", {9'h000, ra}, {9'h000, ram_addr});
		chk("ram_data", {12'h000, e}, {12'h000, ram_data});
	endtask : tbl

	initial
	begin
		error_cnt = 0;
		tests_run = 0;
		nrst = 1'b0;
		clr_n = 1'b1;
		ext_n = 1'b1;
		pins = 4'hF;
		pin_in = 4'h0;
		evs = 5'h00;
		mask = 7'h7F;
		op_valid = 1'b0;
		op_kind = op_step;
		op_target = 11'h000;
		op_data = 4'h0;
		op_ram_addr = 7'h00;
		prog_we = 1'b0;
		prog_addr = 11'h000;
		prog_data = 16'h0000;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		chk("pc", 16'h0000, {5'h00, pc});
		wr(11'h124, 16'hBEEF);
		// ordinary cases
		for (i = 0; i < 6; i++)
		begin
			do_op(rows[i].k, rows[i].t, 4'h0, 7'h00);
			chk("pc", {5'h00, rows[i].e}, {5'h00, pc});
		end
		@(negedge clock);
		chk("instr", 16'hBEEF, instr);
		// table reads, element 7A7 and 002
		wr(11'h7E9, 16'h5A3C);
		tbl(4'hF, 4'hA, 4'h7, 7'h11, 4'h5);
		wr(11'h600, 16'h1234);
		tbl(4'h0, 4'h0, 4'h2, 7'h7F, 4'h2);
		// nine nested calls, eight returns
		do_op(op_jump, 11'h050, 4'h0, 7'h00);
		for (i = 0; i < 9; i++)
		begin
			pre[i] = pc;
			do_op(op_call, 11'h100 + 11'(i * 16), 4'h0, 7'h00);
			chk("pc", 16'h0100 + 16'(i * 16), {5'h00, pc});
		end
		for (i = 8; i > 0; i--)
		begin
			do_op(return_op, 11'h000, 4'h0, 7'h00);
			chk("ret_ofs", 16'h0001, {5'h00, pc - pre[i]});
			chk("pc", {5'h00, pre[i] + `PC_ONE}, {5'h00, pc});
		end
		// call then return back to back
		pre[0] = pc;
		@(posedge clock);
		op_valid <= 1'b1;
		op_kind <= op_call;
		op_target <= 11'h3C0;
		@(posedge clock);
		op_kind <= return_op;
		@(negedge clock);
		chk("pc", 16'h03C0, {5'h00, pc});
		@(posedge clock);
		op_valid <= 1'b0;
		@(negedge clock);
		chk("pc", {5'h00, pre[0] + `PC_ONE}, {5'h00, pc});
		// divider, timer zero, serial and timer one sources alone, then return
		for (j = 0; j < 5; j++)
		begin
			pre[0] = pc;
			pulse(5'h01 << j);
			wait_int(vecs[j], srcs[j]);
			do_op(return_op, 11'h000, 4'h0, 7'h00);
			chk("pc", {5'h00, pre[0]}, {5'h00, pc});
		end
		// divider beats timer one
		pulse(5'h11);
		wait_int(11'h004, 3'h0);
		do_op(return_op, 11'h000, 4'h0, 7'h00);
		wait_int(11'h020, 3'h6);
		do_op(return_op, 11'h000, 4'h0, 7'h00);
		// masked source waits
		@(posedge clock);
		mask <= 7'h00;
		pulse(5'h02);
		no_int();
		@(posedge clock);
		mask <= 7'h7F;
		wait_int(11'h008, 3'h1);
		do_op(return_op, 11'h000, 4'h0, 7'h00);
		// external pin, low active
		@(posedge clock);
		ext_n <= 1'b0;
		wait_int(11'h014, 3'h3);
		do_op(return_op, 11'h000, 4'h0, 7'h00);
		@(posedge clock);
		ext_n <= 1'b1;
		// pin change only as input
		pins <= 4'hB;
		no_int();
		@(posedge clock);
		pins <= 4'hF;
		pin_in <= 4'h4;
		@(posedge clock);
		pins <= 4'hB;
		wait_int(11'h00C, 3'h2);
		do_op(return_op, 11'h000, 4'h0, 7'h00);
		// clear pin low
		do_op(op_jump, 11'h345, 4'h0, 7'h00);
		@(posedge clock);
		clr_n <= 1'b0;
		repeat (4) @(negedge clock);
		chk("pc", 16'h0000, {5'h00, pc});
		chk("op_ready", 16'h0, {15'h0, op_ready});
		@(posedge clock);
		clr_n <= 1'b1;
		repeat (4) @(negedge clock);
		// reset in mid-run
		do_op(op_jump, 11'h2AB, 4'h0, 7'h00);
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		@(negedge clock);
		chk("pc", 16'h0000, {5'h00, pc});
		end_sim();
	end

	initial
	begin
		#20000;
		error_cnt++;
		end_sim();
	end
endmodule : program_sequencer_stack_tb_top

`default_nettype wire
